// ===== core/cos_pkg.sv
// Shared constants and carriers for the CAN object status and identifier tag block.
// Assumes one system clock shared by the CPU special-function-register port and the CAN bit engine.
package cos_pkg;

  // Register addresses on the special-function-register port
  localparam logic [7:0] ADDR_PAGE = 8'hB1;
  localparam logic [7:0] ADDR_STATUS = 8'hB2;
  localparam logic [7:0] ADDR_CTRL = 8'hB3;
  localparam logic [7:0] ADDR_TAG_HIGH = 8'hBC;
  localparam logic [7:0] ADDR_TAG_LOW = 8'hBD;
  localparam logic [7:0] ADDR_TAG_UNUSED = 8'hBE;

  // Object page select fields
  localparam int PAGE_OBJ_LSB = 4;
  localparam int NUM_OBJECTS = 15;
  localparam logic [3:0] LAST_OBJECT = 4'hE;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  // Status flag positions
  localparam int ST_LEN_MISMATCH = 7;
  localparam int ST_TX_DONE = 6;
  localparam int ST_RX_DONE = 5;
  localparam int ST_BIT_ERR = 4;
  localparam int ST_STUFF_ERR = 3;
  localparam int ST_CRC_ERR = 2;
  localparam int ST_FORM_ERR = 1;
  localparam int ST_ACK_ERR = 0;

  // Control and length register fields
  localparam int CTRL_MODE_LSB = 6;
  localparam int CTRL_EXT_BIT = 4;
  localparam logic [1:0] MODE_TX = 2'h1;

  // Tag register layout in standard format
  localparam int TAG_LOW_LSB = 5;
  localparam int ID_STD_BITS = 11;

  // Bus stuffing, CRC and level figures
  localparam int STUFF_LIMIT = 5;
  localparam logic [14:0] CRC_POLY = 15'h4599;
  localparam logic RECESSIVE = 1'b1;
  localparam logic DOMINANT = 1'b0;

  typedef enum logic [3:0] {
    COS_FLD_IDLE, COS_FLD_SOF, COS_FLD_ARB, COS_FLD_CTRL, COS_FLD_DATA, COS_FLD_CRC,
    COS_FLD_CRC_DELIM, COS_FLD_ACK_SLOT, COS_FLD_ACK_DELIM, COS_FLD_EOF, COS_FLD_ERR_FRAME
  } cos_field_t;

  typedef struct packed {
    logic strobe;
    cos_field_t field;
    logic stuff_bit;
    logic transmitting;
    logic tx_level;
  } cos_bit_evt_t;

  typedef struct packed {
    logic valid;
    logic [ID_STD_BITS-1:0] ident;
    logic extended;
    logic [3:0] data_length_code;
    logic [NUM_OBJECTS-1:0] match;
  } cos_rx_evt_t;

endpackage

// ===== core/cos_core.sv
// CAN message object status flags and standard identifier tags, with page select and control.
// Assumes a bit engine on the same clock delivering bit strobes and frame events; bus pin is asynchronous.
//
// Overview of operation
// - Registers act on object chosen by page select
// - Extension bit stops received identifiers from updating the 11 bit tag
// - Length mismatch on receive sets bit 7
// - Received length code always overwrites stored one
// - Finished transmission sets bit 6
// - Lowest numbered transmit object is served first
// - Finished reception sets bit 5
// - Only lowest numbered matching receive object updated
// - Flags in bits 6 to 0 may interrupt; all stay until cleared
// - Transmit level mismatch sets bit error bit 4
// - No bit error for dominant read while recessive sent in arbitration, ack slot, error frame
// - Destuffed CRC mismatch sets bit 2
// - Fixed-form violation sets form error bit 1
// - Tag high holds identifier bits 10 to 3
// - Tag low bits 7 to 5 hold identifier 2 to 0
// - Third tag register reserved, write zeros only
`timescale 1ns/1ps
`default_nettype none

module cos_core #(
  parameter int NUM_OBJ = cos_pkg::NUM_OBJECTS
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic can_rx_pin_in,
  input wire cos_pkg::cos_bit_evt_t bit_evt_in,
  input wire cos_pkg::cos_rx_evt_t rx_evt_in,
  input wire logic tx_done_in,
  input wire logic [3:0] frame_obj_in,
  input wire logic tx_slot_in,
  output logic tx_valid_out,
  output logic [3:0] tx_obj_out,
  output logic [10:0] tx_ident_out,
  output logic [3:0] tx_dlc_out,
  output logic [NUM_OBJ-1:0] obj_event_out
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  // Storage is left without reset: software must load it first
  logic [7:0] status [NUM_OBJ];
  logic [7:0] ctrl [NUM_OBJ];
  logic [10:0] ident [NUM_OBJ];
  logic [7:0] page;
  logic [3:0] cur_obj;
  logic sync1, sync2, rx_level;
  logic [2:0] same_cnt;
  logic last_bit;
  logic [14:0] crc_calc, crc_recv;
  logic [7:0] err_set;
  logic [NUM_OBJ-1:0] tx_enabled, rx_pick, tx_pick, rx_ok_mask;
  logic [3:0] rx_obj, next_tx_obj;
  logic rx_any, tx_any;

  assign cur_obj = page[cos_pkg::PAGE_OBJ_LSB +: 4];

  // Page select; numbers above the last object are clipped
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      page <= cos_pkg::PAGE_RESET;
    else if (sfr_wr_in && hit(sfr_addr_in, cos_pkg::ADDR_PAGE))
    begin
      page <= sfr_wdata_in;
      if (sfr_wdata_in[7:4] > cos_pkg::LAST_OBJECT)
        page[7:4] <= cos_pkg::LAST_OBJECT;
    end
  end

  // Two-flop synchroniser on the bus pin
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      sync1 <= cos_pkg::RECESSIVE;
      sync2 <= cos_pkg::RECESSIVE;
    end
    else
    begin
      sync1 <= can_rx_pin_in;
      sync2 <= sync1;
    end
  end
  assign rx_level = sync2;

  // Priority encoders; lowest index wins
  generate
    for (genvar i = 0; i < NUM_OBJ; i++)
    begin : g_obj
      assign tx_enabled[i] = (ctrl[i][cos_pkg::CTRL_MODE_LSB +: 2] == cos_pkg::MODE_TX);
      assign rx_pick[i] = rx_evt_in.match[i] && ctrl[i][7]
        && ((rx_evt_in.match & ((NUM_OBJ'(1) << i) - NUM_OBJ'(1)) & rx_ok_mask) == '0);
      assign tx_pick[i] = tx_enabled[i] && ((tx_enabled & ((NUM_OBJ'(1) << i) - NUM_OBJ'(1))) == '0);
    end
  endgenerate

  always_comb
  begin
    for (int k = 0; k < NUM_OBJ; k++)
      rx_ok_mask[k] = ctrl[k][7];
  end

  always_comb
  begin
    rx_obj = '0;
    next_tx_obj = '0;
    for (int k = NUM_OBJ - 1; k >= 0; k--)
    begin
      if (rx_pick[k])
        rx_obj = 4'(k);
      if (tx_pick[k])
        next_tx_obj = 4'(k);
    end
  end
  assign rx_any = rx_evt_in.valid && (rx_pick != '0);
  assign tx_any = (tx_enabled != '0);

  // Transmit selection latched at the moment a frame may start
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      tx_valid_out <= 1'b0;
      tx_obj_out <= '0;
      tx_ident_out <= '0;
      tx_dlc_out <= '0;
    end
    else if (tx_slot_in)
    begin
      tx_valid_out <= tx_any;
      tx_obj_out <= next_tx_obj;
      tx_ident_out <= ident[next_tx_obj];
      tx_dlc_out <= ctrl[next_tx_obj][3:0];
    end
  end

  // Run length of equal bus bits where stuffing applies
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      same_cnt <= '0;
      last_bit <= cos_pkg::RECESSIVE;
    end
    else if (bit_evt_in.strobe)
    begin
      last_bit <= rx_level;
      if (bit_evt_in.field == cos_pkg::COS_FLD_SOF || rx_level != last_bit)
        same_cnt <= 3'h1;
      else if (same_cnt != 3'h7)
        same_cnt <= same_cnt + 3'h1;
    end
  end

  // CRC over destuffed bits from start of frame through data; stuff bits skipped
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      crc_calc <= '0;
      crc_recv <= '0;
    end
    else if (bit_evt_in.strobe && !bit_evt_in.stuff_bit)
    begin
      case (bit_evt_in.field)
        cos_pkg::COS_FLD_SOF:
        begin
          crc_calc <= {14'h0000, 1'b0} ^ (rx_level ? cos_pkg::CRC_POLY : 15'h0000);
          crc_recv <= '0;
        end
        cos_pkg::COS_FLD_ARB, cos_pkg::COS_FLD_CTRL, cos_pkg::COS_FLD_DATA:
          crc_calc <= {crc_calc[13:0], 1'b0} ^ ((rx_level ^ crc_calc[14]) ? cos_pkg::CRC_POLY : 15'h0000);
        cos_pkg::COS_FLD_CRC:
          crc_recv <= {crc_recv[13:0], rx_level};
        default:
          crc_recv <= crc_recv;
      endcase
    end
  end

  // Error detection for the current bit
  logic stuff_zone, bit_exempt;
  assign stuff_zone = bit_evt_in.field inside {cos_pkg::COS_FLD_SOF, cos_pkg::COS_FLD_ARB,
    cos_pkg::COS_FLD_CTRL, cos_pkg::COS_FLD_DATA, cos_pkg::COS_FLD_CRC};
  // Losing arbitration or being acknowledged is normal, not an error
  assign bit_exempt = ((bit_evt_in.field inside {cos_pkg::COS_FLD_ARB, cos_pkg::COS_FLD_ACK_SLOT})
    && bit_evt_in.tx_level == cos_pkg::RECESSIVE && rx_level == cos_pkg::DOMINANT)
    || (bit_evt_in.field == cos_pkg::COS_FLD_ERR_FRAME && rx_level == cos_pkg::DOMINANT);

  always_comb
  begin
    err_set = '0;
    if (bit_evt_in.strobe)
    begin
      err_set[cos_pkg::ST_BIT_ERR] = bit_evt_in.transmitting && (rx_level != bit_evt_in.tx_level)
        && !bit_exempt;
      err_set[cos_pkg::ST_STUFF_ERR] = stuff_zone && (rx_level == last_bit)
        && (same_cnt >= 3'(cos_pkg::STUFF_LIMIT));
      err_set[cos_pkg::ST_CRC_ERR] = (bit_evt_in.field == cos_pkg::COS_FLD_CRC_DELIM)
        && (crc_calc != crc_recv);
      err_set[cos_pkg::ST_FORM_ERR] = (bit_evt_in.field inside {cos_pkg::COS_FLD_CRC_DELIM,
        cos_pkg::COS_FLD_ACK_DELIM, cos_pkg::COS_FLD_EOF}) && (rx_level == cos_pkg::DOMINANT);
      err_set[cos_pkg::ST_ACK_ERR] = bit_evt_in.transmitting && (bit_evt_in.field == cos_pkg::COS_FLD_ACK_SLOT)
        && (rx_level == cos_pkg::RECESSIVE);
    end
  end

  // Per-object storage; hardware set wins over a software write in the same cycle
  generate
    for (genvar i = 0; i < NUM_OBJ; i++)
    begin : g_store
      logic sel, rx_me, tx_me, err_me;
      logic [7:0] set_v;
      assign sel = (cur_obj == 4'(i));
      assign rx_me = rx_any && (rx_obj == 4'(i));
      assign tx_me = tx_done_in && (tx_obj_out == 4'(i));
      assign err_me = (frame_obj_in == 4'(i));
      always_comb
      begin
        set_v = err_me ? err_set : 8'h00;
        set_v[cos_pkg::ST_TX_DONE] = tx_me;
        set_v[cos_pkg::ST_RX_DONE] = rx_me;
        set_v[cos_pkg::ST_LEN_MISMATCH] = rx_me && (rx_evt_in.data_length_code != ctrl[i][3:0]);
      end
      assign obj_event_out[i] = |set_v[6:0];

      always_ff @(posedge mclk_in)
      begin
        if (sel && sfr_wr_in && hit(sfr_addr_in, cos_pkg::ADDR_STATUS))
          status[i] <= sfr_wdata_in | set_v;
        else
          status[i] <= status[i] | set_v;
      end

      always_ff @(posedge mclk_in)
      begin
        if (rx_me)
          ctrl[i][3:0] <= rx_evt_in.data_length_code;
        else if (sel && sfr_wr_in && hit(sfr_addr_in, cos_pkg::ADDR_CTRL))
          ctrl[i] <= sfr_wdata_in;
      end

      always_ff @(posedge mclk_in)
      begin
        if (rx_me && !rx_evt_in.extended && !ctrl[i][cos_pkg::CTRL_EXT_BIT])
          ident[i] <= rx_evt_in.ident;
        else if (sel && sfr_wr_in && hit(sfr_addr_in, cos_pkg::ADDR_TAG_HIGH))
          ident[i][10:3] <= sfr_wdata_in;
        else if (sel && sfr_wr_in && hit(sfr_addr_in, cos_pkg::ADDR_TAG_LOW))
          ident[i][2:0] <= sfr_wdata_in[7:cos_pkg::TAG_LOW_LSB];
      end
    end
  endgenerate

  // Read port; reserved bits and the unused tag register read zero
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      sfr_rdata_out <= 8'h00;
    else if (sfr_rd_in)
    begin
      if (hit(sfr_addr_in, cos_pkg::ADDR_PAGE))
        sfr_rdata_out <= page;
      else if (hit(sfr_addr_in, cos_pkg::ADDR_STATUS))
        sfr_rdata_out <= status[cur_obj];
      else if (hit(sfr_addr_in, cos_pkg::ADDR_CTRL))
        sfr_rdata_out <= ctrl[cur_obj];
      else if (hit(sfr_addr_in, cos_pkg::ADDR_TAG_HIGH))
        sfr_rdata_out <= ident[cur_obj][10:3];
      else if (hit(sfr_addr_in, cos_pkg::ADDR_TAG_LOW))
        sfr_rdata_out <= {ident[cur_obj][2:0], 5'h00};
      else
        sfr_rdata_out <= 8'h00;
    end
  end

  // Any write here may move the page or clear the flag before the read
  sequence tx_finish_s;
    tx_done_in && tx_obj_out == cur_obj && !sfr_wr_in;
  endsequence

  sequence status_read_s;
    sfr_rd_in && sfr_addr_in == cos_pkg::ADDR_STATUS && !sfr_wr_in;
  endsequence

  tx_flag_set_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    tx_finish_s ##1 status_read_s |=> sfr_rdata_out[cos_pkg::ST_TX_DONE])
    else $error("transmit complete flag missing");

  flag_sticky_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    status[cur_obj][cos_pkg::ST_RX_DONE] && !(sfr_wr_in && sfr_addr_in == cos_pkg::ADDR_STATUS)
    && !(sfr_wr_in && sfr_addr_in == cos_pkg::ADDR_PAGE) |=> status[cur_obj][cos_pkg::ST_RX_DONE])
    else $error("receive flag dropped without software");

  // Judged from the raw match and enables, not from the encoder's own picks
  rx_priority_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    rx_any |-> rx_evt_in.match[rx_obj] && rx_ok_mask[rx_obj]
    && ((rx_evt_in.match & rx_ok_mask & ((NUM_OBJ'(1) << rx_obj) - NUM_OBJ'(1))) == '0))
    else $error("receive object not lowest match");

  tx_priority_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    tx_slot_in && tx_any && !sfr_wr_in |=> tx_valid_out && tx_enabled[tx_obj_out]
    && ((tx_enabled & ((NUM_OBJ'(1) << tx_obj_out) - NUM_OBJ'(1))) == '0))
    else $error("transmit selection wrong");

  arb_exempt_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    bit_evt_in.strobe && bit_evt_in.field == cos_pkg::COS_FLD_ARB && bit_evt_in.tx_level
    && !rx_level |-> !err_set[cos_pkg::ST_BIT_ERR])
    else $error("bit error raised while losing arbitration");

  bit_err_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    bit_evt_in.strobe && bit_evt_in.transmitting && bit_evt_in.field == cos_pkg::COS_FLD_DATA
    && rx_level != bit_evt_in.tx_level |-> err_set[cos_pkg::ST_BIT_ERR])
    else $error("bit error not raised");

  form_err_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    bit_evt_in.strobe && bit_evt_in.field == cos_pkg::COS_FLD_EOF && !rx_level
    |-> err_set[cos_pkg::ST_FORM_ERR])
    else $error("form error not raised in end of frame");

  len_mismatch_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    rx_any && rx_obj == cur_obj && rx_evt_in.data_length_code != ctrl[cur_obj][3:0]
    && !(sfr_wr_in && sfr_addr_in == cos_pkg::ADDR_PAGE)
    |=> status[cur_obj][cos_pkg::ST_LEN_MISMATCH] && ctrl[cur_obj][3:0] == $past(rx_evt_in.data_length_code))
    else $error("length code not updated");

  tag_read_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    sfr_rd_in && sfr_addr_in == cos_pkg::ADDR_TAG_UNUSED |=> sfr_rdata_out == 8'h00)
    else $error("unused tag register not zero");

endmodule // cos_core

`default_nettype wire

// ===== tb/cos_peer_node.sv
// Peer CAN node sharing the bus with the block under test.
// Assumes the bench supplies the bit engine's view of each bit; the bus is wired-AND.
`timescale 1ns/1ps
`default_nettype none
module cos_peer_node (
  input wire cos_pkg::cos_bit_evt_t bit_evt_in,
  input wire logic ack_en_in,
  input wire logic force_dom_in,
  output logic bus_out
);
  logic own_level;
  logic peer_level;
  assign own_level = bit_evt_in.transmitting ? bit_evt_in.tx_level : cos_pkg::RECESSIVE;
  // Ack only when told, so a silent peer exposes a missing ack
  assign peer_level = ~(force_dom_in | (ack_en_in & (bit_evt_in.field == cos_pkg::COS_FLD_ACK_SLOT)));
  assign bus_out = own_level & peer_level;
endmodule // cos_peer_node
`default_nettype wire

// ===== tb/can_object_status_idtag_tb.sv
// Self-checking bench for the object status and identifier tag block.
// Assumes the peer node model drives the bus pin; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module can_object_status_idtag_tb;
  logic clk, rst, wr, rd, txd, slot, txv, ack_en, fdom, pin;
  logic [7:0] addr, wdata, rdata, st;
  logic [3:0] fobj, txo, txdl;
  logic [10:0] txi;
  logic [14:0] oev;
  cos_pkg::cos_bit_evt_t bev;
  cos_pkg::cos_rx_evt_t rev;
  int fail_count, n_tests, cyc;

  cos_core uut (.mclk_in(clk), .sys_rst_in(rst), .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd),
    .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .can_rx_pin_in(pin), .bit_evt_in(bev), .rx_evt_in(rev),
    .tx_done_in(txd), .frame_obj_in(fobj), .tx_slot_in(slot), .tx_valid_out(txv), .tx_obj_out(txo),
    .tx_ident_out(txi), .tx_dlc_out(txdl), .obj_event_out(oev));
  cos_peer_node peer (.bit_evt_in(bev), .ack_en_in(ack_en), .force_dom_in(fdom), .bus_out(pin));

  task conclude;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string name, input logic [10:0] exp, input logic [10:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task rd_chk(input string name, input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk(name, {3'h0, exp}, {3'h0, rdata & mask});
  endtask

  task page(input logic [3:0] o);
    wr_reg(cos_pkg::ADDR_PAGE, {o, 4'h0});
  endtask

  task strb(input cos_pkg::cos_field_t f, input logic tx, input logic lvl, input logic dom);
    @(negedge clk);
    bev.field = f;
    bev.transmitting = tx;
    bev.tx_level = lvl;
    fdom = dom;
    // Pin passes a two-flop synchroniser before the strobe samples it
    repeat (3) @(negedge clk);
    bev.strobe = 1'b1;
    @(negedge clk);
    bev.strobe = 1'b0;
  endtask

  task init_all;
    for (int o = 0; o < cos_pkg::NUM_OBJECTS; o++)
    begin
      page(o[3:0]);
      wr_reg(cos_pkg::ADDR_CTRL, 8'h00);
      wr_reg(cos_pkg::ADDR_STATUS, 8'h00);
      wr_reg(cos_pkg::ADDR_TAG_HIGH, 8'h00);
      wr_reg(cos_pkg::ADDR_TAG_LOW, 8'h00);
    end
  endtask

  task t_tags;
    page(4'h2);
    wr_reg(cos_pkg::ADDR_TAG_HIGH, 8'hA5);
    wr_reg(cos_pkg::ADDR_TAG_LOW, 8'hE0);
    page(4'hE);
    wr_reg(cos_pkg::ADDR_TAG_HIGH, 8'h3C);
    page(4'h2);
    rd_chk("tag_high_obj2", cos_pkg::ADDR_TAG_HIGH, 8'hFF, 8'hA5);
    rd_chk("tag_low_obj2", cos_pkg::ADDR_TAG_LOW, 8'hE0, 8'hE0);
    rd_chk("tag_unused", cos_pkg::ADDR_TAG_UNUSED, 8'hFF, 8'h00);
    page(4'hE);
    rd_chk("tag_high_obj14", cos_pkg::ADDR_TAG_HIGH, 8'hFF, 8'h3C);
    wr_reg(cos_pkg::ADDR_PAGE, 8'hF0);
    rd_chk("page_clip", cos_pkg::ADDR_PAGE, 8'hF0, 8'hE0);
  endtask

  task t_tx;
    page(4'h4);
    wr_reg(cos_pkg::ADDR_CTRL, 8'h43);
    page(4'h2);
    wr_reg(cos_pkg::ADDR_CTRL, 8'h41);
    @(negedge clk);
    slot = 1'b1;
    @(negedge clk);
    slot = 1'b0;
    chk("tx_valid", 11'h001, {10'h0, txv});
    chk("tx_obj", 11'h002, {7'h0, txo});
    chk("tx_ident", 11'h52F, txi);
    chk("tx_dlc", 11'h001, {7'h0, txdl});
    txd = 1'b1;
    #1;
    chk("tx_event", 11'h004, oev[10:0]);
    // Read straight after the done pulse so the flag check sees it land
    @(negedge clk);
    txd = 1'b0;
    addr = cos_pkg::ADDR_STATUS;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk("status_obj2", 11'h040, {3'h0, rdata});
    page(4'h4);
    rd_chk("status_obj4", cos_pkg::ADDR_STATUS, 8'hFF, 8'h00);
    wr_reg(cos_pkg::ADDR_CTRL, 8'h00);
    page(4'h2);
    wr_reg(cos_pkg::ADDR_CTRL, 8'h00);
    @(negedge clk);
    slot = 1'b1;
    @(negedge clk);
    slot = 1'b0;
    chk("tx_idle", 11'h000, {10'h0, txv});
  endtask

  task t_rx;
    page(4'h9);
    wr_reg(cos_pkg::ADDR_CTRL, 8'h82);
    page(4'h6);
    wr_reg(cos_pkg::ADDR_CTRL, 8'h82);
    @(negedge clk);
    rev = '{valid: 1'b1, ident: 11'h5A3, extended: 1'b0, data_length_code: 4'h5, match: 15'h0240};
    #1;
    chk("rx_event", 11'h040, oev[10:0]);
    @(negedge clk);
    rev.valid = 1'b0;
    rd_chk("status_obj6", cos_pkg::ADDR_STATUS, 8'hFF, 8'hA0);
    rd_chk("ctrl_obj6", cos_pkg::ADDR_CTRL, 8'h0F, 8'h05);
    rd_chk("rx_tag_high", cos_pkg::ADDR_TAG_HIGH, 8'hFF, 8'hB4);
    rd_chk("rx_tag_low", cos_pkg::ADDR_TAG_LOW, 8'hE0, 8'h60);
    // Extended frame: length code still lands, standard tag stays
    @(negedge clk);
    rev = '{valid: 1'b1, ident: 11'h0F0, extended: 1'b1, data_length_code: 4'h0, match: 15'h0040};
    @(negedge clk);
    rev.valid = 1'b0;
    rd_chk("ext_keeps_tag", cos_pkg::ADDR_TAG_HIGH, 8'hFF, 8'hB4);
    rd_chk("ext_dlc", cos_pkg::ADDR_CTRL, 8'h0F, 8'h00);
    page(4'h9);
    rd_chk("status_obj9", cos_pkg::ADDR_STATUS, 8'hFF, 8'h00);
  endtask

  task t_err;
    fobj = 4'h7;
    page(4'h7);
    strb(cos_pkg::COS_FLD_ARB, 1'b1, 1'b1, 1'b1);
    rd_chk("arb_no_bit_err", cos_pkg::ADDR_STATUS, 8'h10, 8'h00);
    strb(cos_pkg::COS_FLD_DATA, 1'b1, 1'b1, 1'b1);
    strb(cos_pkg::COS_FLD_ACK_SLOT, 1'b1, 1'b1, 1'b0);
    strb(cos_pkg::COS_FLD_CRC_DELIM, 1'b0, 1'b1, 1'b1);
    rd_chk("bit_err", cos_pkg::ADDR_STATUS, 8'h10, 8'h10);
    rd_chk("ack_err", cos_pkg::ADDR_STATUS, 8'h01, 8'h01);
    rd_chk("form_err", cos_pkg::ADDR_STATUS, 8'h02, 8'h02);
  endtask

  task t_crc;
    fobj = 4'h8;
    page(4'h8);
    strb(cos_pkg::COS_FLD_SOF, 1'b0, 1'b1, 1'b1);
    // All-recessive CRC field: wrong sum and a stuffing breach at once
    repeat (15) strb(cos_pkg::COS_FLD_CRC, 1'b0, 1'b1, 1'b0);
    strb(cos_pkg::COS_FLD_CRC_DELIM, 1'b0, 1'b1, 1'b0);
    rd_chk("crc_err", cos_pkg::ADDR_STATUS, 8'h04, 8'h04);
    rd_chk("stuff_err", cos_pkg::ADDR_STATUS, 8'h08, 8'h08);
    repeat (4) @(negedge clk);
    rd_chk("flags_sticky", cos_pkg::ADDR_STATUS, 8'h0C, 8'h0C);
    wr_reg(cos_pkg::ADDR_STATUS, 8'h00);
    rd_chk("flags_cleared", cos_pkg::ADDR_STATUS, 8'hFF, 8'h00);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Whole run needs a few hundred cycles; ceiling leaves wide margin
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      conclude;
    end
  end

  initial
  begin
    {rst, wr, rd, txd, slot, ack_en, fdom} = 7'h40;
    {addr, wdata, fobj} = 20'h00000;
    bev = '0;
    rev = '0;
    fail_count = 0;
    n_tests = 0;
    cyc = 0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    init_all;
    t_tags;
    t_tx;
    t_rx;
    t_err;
    t_crc;
    conclude;
  end
endmodule // can_object_status_idtag_tb
`default_nettype wire
